// ===== bcsc_charge_ctrl.sv
// Behaviour
// - Two four-level straps decode to a cell count of 1 to 16, low strap stepping within a group.
// - The interval strap picks the sampling interval and timeout pair; the other picks short or long.
// - The controller is always in exactly one of fast or trickle, dropping to trickle on full charge.
// - Slope, temperature or elapsed time, any one met, ends fast charge.
// - Reset forces trickle; on release fast starts if the per-cell voltage is above lockout.
// - Fast charge is blocked until battery voltage over cell count exceeds 0.4 V.
// - With slope termination enabled by the second strap, a falling cell voltage ends fast charge.
// - A pack cold at power-up stays in trickle and starts fast charge once it first warms into the safe range.
// - Rising above the hot limit during fast charge reverts to trickle.
// - With no battery, current into a newly inserted battery starts fast charge.
// - With no battery the output is limited to cells times the per-cell limit, also after removal.
// - Slope sampling uses battery voltage divided by the programmed cell count.
// - Only the first warm edge after a cold power-up starts fast charge.
// - A pack hot at power-up or insertion never fast charges until the next reset.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "bcsc_defines.svh"

module bcsc_charge_ctrl #(
   parameter int CYCLES_PER_SECOND = `BCSC_SECOND_NS / `BCSC_CLK_PERIOD_NS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] cell_count_strap_high,
   input wire logic [1:0] cell_count_strap_low,
   input wire logic [1:0] timeout_select_strap,
   input wire logic [1:0] interval_select_strap,
   input wire logic [15:0] negative_terminal_level,
   input wire logic battery_current,
   input wire logic below_cold_threshold,
   input wire logic above_hot_threshold,
   output logic fast_charge,
   output logic voltage_limit_active,
   output logic [19:0] output_voltage_limit,
   output logic irq
);

   logic strap_valid;
   logic [4:0] cell_count;
   logic [7:0] interval_s;
   logic [8:0] timeout_min;
   logic slope_enable;
   bcsc_pkg::bcsc_state_e state;
   bcsc_pkg::bcsc_state_e next_state;
   logic hold_trickle;
   logic [15:0] per_cell_limit_voltage;
   logic [`BCSC_EV_WIDTH-1:0] int_status;
   logic [`BCSC_EV_WIDTH-1:0] int_mask;
   logic [`BCSC_EV_WIDTH-1:0] events;
   logic [15:0] per_cell_mv;
   logic [15:0] peak_mv;
   logic undervoltage_lockout;
   logic uv_prev;
   logic present_prev;
   logic cold_prev;
   logic hot_prev;
   logic powered;
   logic power_up;
   logic hot_lock;
   logic cold_armed;
   logic [31:0] prescale;
   logic sec_tick;
   logic [7:0] sample_cnt;
   logic sample_tick;
   logic [5:0] sec_in_min;
   logic [8:0] elapsed_min;
   logic timeout_hit;
   logic slope_hit;
   logic entry_ok;
   logic start_fast;
   logic apb_access;
   logic apb_setup;
   logic addr_hit;
   logic clear_int;
   logic [`BCSC_EV_WIDTH-1:0] read_clear;
   logic [`BCSC_EV_WIDTH-1:0] next_int_status;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] per_cell(input logic [15:0] total, input logic [4:0] cells);
      per_cell = total / {11'h000, cells};
   endfunction

   function automatic logic slope_fall(input logic [15:0] now, input logic [15:0] peak);
      slope_fall = ({1'b0, now} + {1'b0, `BCSC_SLOPE_DROP_MV}) < {1'b0, peak};
   endfunction

   function automatic logic mapped(input logic [7:0] addr);
      mapped = (addr == `BCSC_CTRL_OFS) || (addr == `BCSC_STATUS_OFS)
            || (addr == `BCSC_LIMIT_OFS) || (addr == `BCSC_PROGRESS_OFS)
            || (addr == `BCSC_INT_STATUS_OFS) || (addr == `BCSC_INT_MASK_OFS);
   endfunction

   // ---------------------------------------------------------------
   // Straps
   // ---------------------------------------------------------------
   bcsc_strap_decode u_strap (
      .pclk(pclk),
      .presetn(presetn),
      .cell_count_strap_high(cell_count_strap_high),
      .cell_count_strap_low(cell_count_strap_low),
      .timeout_select_strap(timeout_select_strap),
      .interval_select_strap(interval_select_strap),
      .strap_valid(strap_valid),
      .cell_count(cell_count),
      .interval_s(interval_s),
      .timeout_min(timeout_min),
      .slope_enable(slope_enable)
   );

   // ---------------------------------------------------------------
   // Per-cell voltage and lockout
   // ---------------------------------------------------------------
   // converter sees total over cell count
   assign per_cell_mv = per_cell(negative_terminal_level, cell_count);
   // lockout at 0.4 V per cell
   assign undervoltage_lockout = per_cell_mv <= `BCSC_UNDERVOLTAGE_LOCKOUT_MV;

   // Previous input levels for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uv_prev <= 1'b1;
         present_prev <= 1'b0;
         cold_prev <= 1'b0;
         hot_prev <= 1'b0;
         powered <= 1'b0;
      end else begin
         uv_prev <= undervoltage_lockout;
         present_prev <= battery_current;
         cold_prev <= below_cold_threshold;
         hot_prev <= above_hot_threshold;
         powered <= strap_valid;
      end
   end

   // Straps become valid one cycle after release; decisions wait for them
   assign power_up = strap_valid && !powered;

   // hot at power-up or insertion locks out fast charge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hot_lock <= 1'b0;
      end else if (above_hot_threshold
                   && (power_up || (powered && battery_current && !present_prev))) begin
         hot_lock <= 1'b1;
      end
   end

   // armed by a cold power-up, spent by the first warm edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cold_armed <= 1'b0;
      end else if (power_up) begin
         cold_armed <= below_cold_threshold;
      end else if (powered && cold_prev && !below_cold_threshold) begin
         cold_armed <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Timers, run only in fast charge
   // ---------------------------------------------------------------
   assign sec_tick = prescale == 32'(CYCLES_PER_SECOND - 1);
   assign sample_tick = sec_tick && (sample_cnt == interval_s - 8'h01);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= 32'h0;
      end else if (state != bcsc_pkg::BCSC_FAST || sec_tick) begin
         prescale <= 32'h0;
      end else begin
         prescale <= prescale + 32'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_cnt <= 8'h00;
      end else if (state != bcsc_pkg::BCSC_FAST || sample_tick) begin
         sample_cnt <= 8'h00;
      end else if (sec_tick) begin
         sample_cnt <= sample_cnt + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_in_min <= 6'h00;
         elapsed_min <= 9'h000;
      end else if (start_fast) begin
         sec_in_min <= 6'h00;
         elapsed_min <= 9'h000;
      end else if (state == bcsc_pkg::BCSC_FAST && sec_tick) begin
         if (sec_in_min == `BCSC_SECONDS_PER_MINUTE - 6'h01) begin
            sec_in_min <= 6'h00;
            elapsed_min <= elapsed_min + 9'h001;
         end else begin
            sec_in_min <= sec_in_min + 6'h01;
         end
      end
   end

   assign timeout_hit = elapsed_min >= timeout_min;

   // peak tracking on each sample; with slope enabled, a drop of more than 4 mV below peak ends fast charge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peak_mv <= 16'h0000;
      end else if (start_fast) begin
         peak_mv <= per_cell_mv;
      end else if (sample_tick && per_cell_mv > peak_mv) begin
         peak_mv <= per_cell_mv;
      end
   end

   assign slope_hit = slope_enable && sample_tick && slope_fall(per_cell_mv, peak_mv);

   // ---------------------------------------------------------------
   // Charge state
   // ---------------------------------------------------------------
   // common entry qualifiers
   assign entry_ok = !undervoltage_lockout && battery_current && !below_cold_threshold
                   && !above_hot_threshold && !hot_lock && !hold_trickle;

   always_comb begin
      next_state = state;
      start_fast = 1'b0;
      events = '0;
      unique case (state)
         bcsc_pkg::BCSC_TRICKLE: begin
            // entry on power-up, lockout release, insertion, first warm edge
            if (entry_ok && (power_up
                             || (powered && uv_prev)
                             || (powered && !present_prev)
                             || (powered && cold_prev && cold_armed))) begin
               next_state = bcsc_pkg::BCSC_FAST;
               start_fast = 1'b1;
               events[`BCSC_EV_FAST_START] = 1'b1;
            end
         end
         bcsc_pkg::BCSC_FAST: begin
            // any terminating condition returns to trickle
            if (slope_hit || timeout_hit || above_hot_threshold || !battery_current
                || undervoltage_lockout || hold_trickle) begin
               next_state = bcsc_pkg::BCSC_TRICKLE;
            end
            events[`BCSC_EV_SLOPE_END] = slope_hit;
            events[`BCSC_EV_TIMEOUT_END] = timeout_hit;
            events[`BCSC_EV_HOT_END] = above_hot_threshold;
            events[`BCSC_EV_REMOVED] = !battery_current;
            events[`BCSC_EV_UNDERVOLT_END] = undervoltage_lockout;
         end
      endcase
   end

   // single state bit, trickle under reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= bcsc_pkg::BCSC_TRICKLE;
      end else begin
         state <= next_state;
      end
   end

   assign fast_charge = state == bcsc_pkg::BCSC_FAST;

   // limit output voltage while no battery draws current
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         voltage_limit_active <= 1'b1;
         output_voltage_limit <= 20'h00000;
      end else begin
         voltage_limit_active <= !battery_current;
         output_voltage_limit <= 20'({16'h0000, cell_count} * {5'h00, per_cell_limit_voltage});
      end
   end

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   // Read data is staged in setup, so every access completes without wait states
   assign apb_setup = psel && !penable;
   assign apb_access = psel && penable;
   assign pready = apb_access;
   assign addr_hit = mapped(paddr);
   assign pslverr = apb_access && !addr_hit;
   assign clear_int = apb_access && !pwrite && paddr == `BCSC_INT_STATUS_OFS;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_trickle <= `BCSC_CTRL_RESET;
         per_cell_limit_voltage <= `BCSC_LIMIT_RESET;
         int_mask <= `BCSC_INT_MASK_RESET;
      end else if (apb_access && pwrite) begin
         if (paddr == `BCSC_CTRL_OFS) begin
            hold_trickle <= pwdata[`BCSC_CTRL_HOLD_BIT];
         end
         if (paddr == `BCSC_LIMIT_OFS) begin
            per_cell_limit_voltage <= pwdata[15:0];
         end
         if (paddr == `BCSC_INT_MASK_OFS) begin
            int_mask <= pwdata[`BCSC_EV_WIDTH-1:0];
         end
      end
   end

   // Only the bits the read returned are cleared, so an event in the setup cycle is not lost;
   // a new event wins over the clear
   assign read_clear = prdata[`BCSC_EV_WIDTH-1:0] & {`BCSC_EV_WIDTH{clear_int}};
   assign next_int_status = (int_status & ~read_clear) | events;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status <= '0;
      end else begin
         int_status <= next_int_status;
      end
   end

   // Follows the status as it will stand, so a clearing read drops it at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_int_status & int_mask);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (apb_setup) begin
         prdata <= 32'h00000000;
         unique case (paddr)
            `BCSC_CTRL_OFS: prdata[`BCSC_CTRL_HOLD_BIT] <= hold_trickle;
            `BCSC_STATUS_OFS: prdata <= {7'h00, timeout_min, 3'h0, cell_count,
                                         1'b0, slope_enable, battery_current, hot_lock,
                                         above_hot_threshold, below_cold_threshold,
                                         undervoltage_lockout, fast_charge};
            `BCSC_LIMIT_OFS: prdata[15:0] <= per_cell_limit_voltage;
            `BCSC_PROGRESS_OFS: prdata <= {per_cell_mv, 7'h00, elapsed_min};
            `BCSC_INT_STATUS_OFS: prdata[`BCSC_EV_WIDTH-1:0] <= int_status | events;
            `BCSC_INT_MASK_OFS: prdata[`BCSC_EV_WIDTH-1:0] <= int_mask;
            default: prdata <= 32'h00000000;
         endcase
      end
   end

endmodule // bcsc_charge_ctrl

// ===== bcsc_charge_ctrl_assertions.sv
`timescale 1ns/1ps
module bcsc_charge_ctrl_checker #(
   parameter int CYCLES_PER_SECOND = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] cell_count_strap_high,
   input wire logic [1:0] cell_count_strap_low,
   input wire logic [15:0] negative_terminal_level,
   input wire logic battery_current,
   input wire logic below_cold_threshold,
   input wire logic above_hot_threshold,
   input wire logic fast_charge,
   input wire logic voltage_limit_active
);
   logic [15:0] per_cell;
   // Straps are held steady by the bench, so the live pins match the captured count
   assign per_cell = negative_terminal_level / (16'({cell_count_strap_high,
      cell_count_strap_low}) + 16'h0001);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   reset_trickle_a: assert property (!$past(presetn) |=> !fast_charge)
      else $error("fast charge right after reset");
   hot_exit_a: assert property (fast_charge && above_hot_threshold |=> !fast_charge)
      else $error("hot pack kept in fast charge");
   cold_hold_a: assert property (!fast_charge && below_cold_threshold |=> !fast_charge)
      else $error("cold pack entered fast charge");
   hot_hold_a: assert property (!fast_charge && above_hot_threshold |=> !fast_charge)
      else $error("hot pack entered fast charge");
   current_lost_a: assert property (!battery_current |=> !fast_charge && voltage_limit_active)
      else $error("no pack but no voltage limiting");
   limit_release_a: assert property (battery_current |=> !voltage_limit_active)
      else $error("limiting kept with pack present");
   undervolt_a: assert property (per_cell <= 16'h0190 |=> !fast_charge)
      else $error("fast charge below lockout");
   entry_cause_a: assert property ($rose(fast_charge) |-> $past(battery_current) &&
      !$past(above_hot_threshold) && !$past(below_cold_threshold))
      else $error("fast entry without its conditions");
endmodule // bcsc_charge_ctrl_checker

bind bcsc_charge_ctrl bcsc_charge_ctrl_checker #(.CYCLES_PER_SECOND(CYCLES_PER_SECOND)) u_chk (
   .pclk(pclk), .presetn(presetn), .cell_count_strap_high(cell_count_strap_high),
   .cell_count_strap_low(cell_count_strap_low), .negative_terminal_level(negative_terminal_level),
   .battery_current(battery_current), .below_cold_threshold(below_cold_threshold),
   .above_hot_threshold(above_hot_threshold), .fast_charge(fast_charge),
   .voltage_limit_active(voltage_limit_active));

// ===== bcsc_defines.svh
`ifndef BCSC_DEFINES_SVH
`define BCSC_DEFINES_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define BCSC_CTRL_OFS 8'h00
`define BCSC_STATUS_OFS 8'h04
`define BCSC_LIMIT_OFS 8'h08
`define BCSC_PROGRESS_OFS 8'h0C
`define BCSC_INT_STATUS_OFS 8'h10
`define BCSC_INT_MASK_OFS 8'h14

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define BCSC_CTRL_HOLD_BIT 0
`define BCSC_CTRL_RESET 1'h0
`define BCSC_LIMIT_RESET 16'h076C
`define BCSC_INT_MASK_RESET 6'h00
`define BCSC_EV_FAST_START 0
`define BCSC_EV_SLOPE_END 1
`define BCSC_EV_HOT_END 2
`define BCSC_EV_TIMEOUT_END 3
`define BCSC_EV_REMOVED 4
`define BCSC_EV_UNDERVOLT_END 5
`define BCSC_EV_WIDTH 6

// ---------------------------------------------------------------
// Voltages in millivolts per cell
// ---------------------------------------------------------------
`define BCSC_UNDERVOLTAGE_LOCKOUT_MV 16'h0190
`define BCSC_SLOPE_DROP_MV 16'h0004

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define BCSC_CLK_PERIOD_NS 10
`define BCSC_SECOND_NS 1000000000
`define BCSC_SECONDS_PER_MINUTE 6'h3C
`define BCSC_INTERVAL_SUPPLY_S 8'h15
`define BCSC_INTERVAL_FLOAT_S 8'h2A
`define BCSC_INTERVAL_MID_S 8'h54
`define BCSC_INTERVAL_NEG_S 8'hA8
`define BCSC_TIMEOUT_SUPPLY_SHORT_MIN 9'h016
`define BCSC_TIMEOUT_SUPPLY_LONG_MIN 9'h021
`define BCSC_TIMEOUT_FLOAT_SHORT_MIN 9'h02D
`define BCSC_TIMEOUT_FLOAT_LONG_MIN 9'h042
`define BCSC_TIMEOUT_MID_SHORT_MIN 9'h05A
`define BCSC_TIMEOUT_MID_LONG_MIN 9'h084
`define BCSC_TIMEOUT_NEG_SHORT_MIN 9'h0B4
`define BCSC_TIMEOUT_NEG_LONG_MIN 9'h108

`endif

// ===== bcsc_pack_model.sv
`timescale 1ns/1ps
// Pack with thermistor comparators; no pack means no stack voltage and no current
module bcsc_pack_model (
   input wire logic present,
   input wire logic [15:0] cell_mv,
   input wire logic [4:0] cells,
   input wire logic cold,
   input wire logic hot,
   output logic [15:0] negative_terminal_level,
   output logic battery_current,
   output logic below_cold_threshold,
   output logic above_hot_threshold
);
   assign negative_terminal_level = present ? 16'(cell_mv * cells) : 16'h0000;
   assign battery_current = present;
   assign below_cold_threshold = cold;
   assign above_hot_threshold = hot;
endmodule // bcsc_pack_model

// ===== bcsc_pkg.sv
package bcsc_pkg;

   // Four-level strap as seen by the level comparators
   typedef enum logic [1:0] {
      BCSC_LVL_SUPPLY = 2'b00,
      BCSC_LVL_FLOAT = 2'b01,
      BCSC_LVL_MID = 2'b10,
      BCSC_LVL_NEG = 2'b11
   } bcsc_level_e;

   typedef enum logic {
      BCSC_TRICKLE = 1'b0,
      BCSC_FAST = 1'b1
   } bcsc_state_e;

endpackage

// ===== bcsc_strap_decode.sv
`timescale 1ns/1ps
`include "bcsc_defines.svh"

module bcsc_strap_decode (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] cell_count_strap_high,
   input wire logic [1:0] cell_count_strap_low,
   input wire logic [1:0] timeout_select_strap,
   input wire logic [1:0] interval_select_strap,
   output logic strap_valid,
   output logic [4:0] cell_count,
   output logic [7:0] interval_s,
   output logic [8:0] timeout_min,
   output logic slope_enable
);

   logic short_timeout;

   // ---------------------------------------------------------------
   // Strap capture
   // ---------------------------------------------------------------
   // capture once after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_valid <= 1'b0;
      end else begin
         strap_valid <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cell_count <= 5'h01;
      end else if (!strap_valid) begin
         cell_count <= 5'({cell_count_strap_high, cell_count_strap_low}) + 5'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slope_enable <= 1'b0;
      end else if (!strap_valid) begin
         slope_enable <= timeout_select_strap[1];
      end
   end

   assign short_timeout = (timeout_select_strap == bcsc_pkg::BCSC_LVL_FLOAT)
                        || (timeout_select_strap == bcsc_pkg::BCSC_LVL_MID);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interval_s <= `BCSC_INTERVAL_SUPPLY_S;
         timeout_min <= `BCSC_TIMEOUT_SUPPLY_SHORT_MIN;
      end else if (!strap_valid) begin
         unique case (bcsc_pkg::bcsc_level_e'(interval_select_strap))
            bcsc_pkg::BCSC_LVL_SUPPLY: begin
               interval_s <= `BCSC_INTERVAL_SUPPLY_S;
               timeout_min <= short_timeout ? `BCSC_TIMEOUT_SUPPLY_SHORT_MIN
                                            : `BCSC_TIMEOUT_SUPPLY_LONG_MIN;
            end
            bcsc_pkg::BCSC_LVL_FLOAT: begin
               interval_s <= `BCSC_INTERVAL_FLOAT_S;
               timeout_min <= short_timeout ? `BCSC_TIMEOUT_FLOAT_SHORT_MIN
                                            : `BCSC_TIMEOUT_FLOAT_LONG_MIN;
            end
            bcsc_pkg::BCSC_LVL_MID: begin
               interval_s <= `BCSC_INTERVAL_MID_S;
               timeout_min <= short_timeout ? `BCSC_TIMEOUT_MID_SHORT_MIN
                                            : `BCSC_TIMEOUT_MID_LONG_MIN;
            end
            bcsc_pkg::BCSC_LVL_NEG: begin
               interval_s <= `BCSC_INTERVAL_NEG_S;
               timeout_min <= short_timeout ? `BCSC_TIMEOUT_NEG_SHORT_MIN
                                            : `BCSC_TIMEOUT_NEG_LONG_MIN;
            end
         endcase
      end
   end

endmodule // bcsc_strap_decode

// ===== test_battery_charge_state_control.sv
`timescale 1ns/1ps
`include "bcsc_defines.svh"
module test_battery_charge_state_control;
   // Ten cycles a second keeps the 22 minute timeout near 13200 cycles
   localparam int CPS = 10;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [1:0] s_hi = 0, s_lo = 0, s_to = 0, s_iv = 0;
   logic present = 0, cold = 0, hot = 0, pready, pslverr, fast_charge, vla, irq;
   logic [15:0] cell_mv = 16'h0000, level;
   logic bcur, bcold, bhot;
   logic [19:0] ovl;
   logic [31:0] exp_q[$], msk_q[$];
   logic [8:0] tmo_tab[8] = '{9'h021, 9'h042, 9'h084, 9'h108, 9'h016, 9'h02D, 9'h05A, 9'h0B4};
   int err_total = 0, n_tests = 0, cyc = 0;
   integer seed = 32'hA9DC;
   always #5 pclk = ~pclk;
   bcsc_charge_ctrl #(.CYCLES_PER_SECOND(CPS)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cell_count_strap_high(s_hi),
      .cell_count_strap_low(s_lo), .timeout_select_strap(s_to), .interval_select_strap(s_iv),
      .negative_terminal_level(level), .battery_current(bcur), .below_cold_threshold(bcold),
      .above_hot_threshold(bhot), .fast_charge(fast_charge), .voltage_limit_active(vla),
      .output_voltage_limit(ovl), .irq(irq));
   bcsc_pack_model pack (.present(present), .cell_mv(cell_mv),
      .cells(5'({s_hi, s_lo}) + 5'h01), .cold(cold), .hot(hot),
      .negative_terminal_level(level), .battery_current(bcur),
      .below_cold_threshold(bcold), .above_hot_threshold(bhot));
   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   task wrap_up;
      if (err_total == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      msk_q.push_back(m);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task step;
      repeat (3) @(posedge pclk);
   endtask
   task boot(input logic [1:0] h, l, t, v, input logic c, o);
      presetn <= 1'b0;
      s_hi <= h;
      s_lo <= l;
      s_to <= t;
      s_iv <= v;
      cold <= c;
      hot <= o;
      present <= 1'b1;
      cell_mv <= 16'(1300 + {$random(seed)} % 300);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      step;
   endtask
   // Read data is judged at the edge that completes the access
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         cmp("read data", exp_q.pop_front(), prdata & msk_q.pop_front());
         cmp("slave error", 32'(paddr > `BCSC_INT_MASK_OFS), 32'(pslverr));
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         wrap_up;
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      @(posedge pclk);
      for (int k = 0; k < 16; k++) begin
         boot(k[3:2], k[1:0], k[1:0], k[3:2], 1'b0, 1'b0);
         rd(`BCSC_STATUS_OFS, 32'h01FF1F41, {7'h0, tmo_tab[{k[1] ^ k[0], k[3:2]}], 3'h0,
            5'(k + 1), 1'b0, k[1], 5'h00, 1'b1});
         cmp("voltage limit", 32'((k + 1) * 1900), 32'(ovl));
      end
      boot(2'h0, 2'h3, 2'h3, 2'h0, 1'b0, 1'b0);
      cmp("irq masked", 32'h0, 32'(irq));
      apb(1'b1, `BCSC_INT_MASK_OFS, 32'h0000003F);
      rd(`BCSC_LIMIT_OFS, 32'h0000FFFF, 32'h0000076C);
      rd(8'h18, 32'hFFFFFFFF, 32'h0);
      apb(1'b1, `BCSC_LIMIT_OFS, 32'h00000708);
      rd(`BCSC_LIMIT_OFS, 32'h0000FFFF, 32'h00000708);
      cmp("voltage limit", 32'h00001C20, 32'(ovl));
      hot <= 1'b1;
      step;
      rd(`BCSC_STATUS_OFS, 32'h1, 32'h0);
      cmp("irq raised", 32'h1, 32'(irq));
      rd(`BCSC_INT_STATUS_OFS, 32'h4, 32'h4);
      rd(`BCSC_INT_STATUS_OFS, 32'h3F, 32'h0);
      cmp("irq cleared", 32'h0, 32'(irq));
      hot <= 1'b0;
      present <= 1'b0;
      step;
      cmp("limit active", 32'h1, 32'(vla));
      present <= 1'b1;
      step;
      rd(`BCSC_STATUS_OFS, 32'h1, 32'h1);
      cell_mv <= 16'h0190;
      step;
      rd(`BCSC_STATUS_OFS, 32'h1, 32'h0);
      cell_mv <= 16'h05DC;
      step;
      rd(`BCSC_STATUS_OFS, 32'h1, 32'h1);
      repeat (500) @(posedge pclk);
      cell_mv <= 16'h05D2;
      repeat (500) @(posedge pclk);
      rd(`BCSC_STATUS_OFS, 32'h1, 32'h0);
      boot(2'h0, 2'h3, 2'h3, 2'h0, 1'b1, 1'b0);
      rd(`BCSC_STATUS_OFS, 32'h1, 32'h0);
      cold <= 1'b0;
      step;
      rd(`BCSC_STATUS_OFS, 32'h1, 32'h1);
      apb(1'b1, `BCSC_CTRL_OFS, 32'h1);
      apb(1'b1, `BCSC_CTRL_OFS, 32'h0);
      cold <= 1'b1;
      step;
      cold <= 1'b0;
      step;
      rd(`BCSC_STATUS_OFS, 32'h1, 32'h0);
      boot(2'h0, 2'h3, 2'h3, 2'h0, 1'b0, 1'b1);
      hot <= 1'b0;
      present <= 1'b0;
      step;
      present <= 1'b1;
      step;
      rd(`BCSC_STATUS_OFS, 32'h1, 32'h0);
      boot(2'h0, 2'h3, 2'h1, 2'h0, 1'b0, 1'b0);
      repeat (13100) @(posedge pclk);
      rd(`BCSC_STATUS_OFS, 32'h1, 32'h1);
      repeat (200) @(posedge pclk);
      rd(`BCSC_STATUS_OFS, 32'h1, 32'h0);
      wrap_up;
   end
endmodule // test_battery_charge_state_control
